/* File: cascadable_down_timer_pair.sv */
// Purpose: Two cascadable 16-bit down timers behind an AXI4-Lite slave
// Assumes: Pins synchronous to nothing; clock_i at 125 MHz
// Notes: Timer 1 may use timer 0 underflow as event or trigger
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module cascadable_down_timer_pair import timer_pair_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic first_timer_trigger_pin_i,
  input wire logic second_timer_trigger_pin_i,
  input wire logic shared_port_pin_i,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe_n_o,
  output logic second_timer_pulse_pin_o
);
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [WIDTH-1:0] reload0;
  logic [WIDTH-1:0] reload1;
  logic load0;
  logic load1;
  logic [1:0] flags;
  logic [1:0] flag_clr;
  logic [WIDTH-1:0] count0;
  logic [WIDTH-1:0] count1;
  logic uf0;
  logic uf1;
  logic active1;
  logic pulse0;
  logic pulse1;
  logic level0;
  logic rise0;
  logic fall0;
  logic rise1;
  logic fall1;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Apply byte strobes to a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i+:8] = val[8*i+:8];
      end
    end
    return res;
  endfunction

  // Write channels accepted independently, one write in flight
  assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_hold && !s_axi_bvalid_o;
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid_o;

  // Hold address and data until both have arrived
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_hold <= 1'b0;
      end
    end
  end

  // Write response with error for unmapped addresses
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      if (aw_addr == CTRL0_OFFSET || aw_addr == RELOAD0_OFFSET
          || aw_addr == CTRL1_OFFSET || aw_addr == RELOAD1_OFFSET
          || aw_addr == STATUS_OFFSET || aw_addr == COUNT0_OFFSET
          || aw_addr == COUNT1_OFFSET) begin
        s_axi_bresp_o <= RESP_OKAY;
      end else begin
        s_axi_bresp_o <= RESP_SLVERR;
      end
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Control and reload registers; counter load follows a reload write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl0 <= CTRL_RESET;
      ctrl1 <= CTRL_RESET;
      reload0 <= RELOAD_RESET;
      reload1 <= RELOAD_RESET;
      load0 <= 1'b0;
      load1 <= 1'b0;
    end else begin
      load0 <= 1'b0;
      load1 <= 1'b0;
      if (wr_fire) begin
        if (aw_addr == CTRL0_OFFSET) begin
          ctrl0 <= 8'(merge({24'h0, ctrl0}, w_data, w_strb));
        end else if (aw_addr == CTRL1_OFFSET) begin
          ctrl1 <= 8'(merge({24'h0, ctrl1}, w_data, w_strb));
        end else if (aw_addr == RELOAD0_OFFSET) begin
          reload0 <= WIDTH'(merge({16'h0, reload0}, w_data, w_strb));
          load0 <= 1'b1;
        end else if (aw_addr == RELOAD1_OFFSET) begin
          reload1 <= WIDTH'(merge({16'h0, reload1}, w_data, w_strb));
          load1 <= 1'b1;
        end
      end
    end
  end

  // Write-one-to-clear on the request flags
  assign flag_clr = (wr_fire && aw_addr == STATUS_OFFSET && w_strb[0])
    ? w_data[1:0] : 2'b00;

  // Sticky request flags; a new underflow beats a clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= 2'b00;
    end else begin
      flags <= (flags & ~flag_clr) | {uf1, uf0};
    end
  end

  // Read data selection
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    if (s_axi_araddr_i == CTRL0_OFFSET) begin
      next_rdata = {24'h0, ctrl0};
    end else if (s_axi_araddr_i == RELOAD0_OFFSET) begin
      next_rdata = {16'h0, reload0};
    end else if (s_axi_araddr_i == COUNT0_OFFSET) begin
      next_rdata = {16'h0, count0};
    end else if (s_axi_araddr_i == CTRL1_OFFSET) begin
      next_rdata = {24'h0, ctrl1};
    end else if (s_axi_araddr_i == RELOAD1_OFFSET) begin
      next_rdata = {16'h0, reload1};
    end else if (s_axi_araddr_i == COUNT1_OFFSET) begin
      next_rdata = {16'h0, count1};
    end else if (s_axi_araddr_i == STATUS_OFFSET) begin
      next_rdata = {29'h0, level0, flags};
    end else begin
      next_rresp = RESP_SLVERR;
    end
  end

  // Read channel, one read in flight
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rresp;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // Trigger and event pin synchronisers
  pin_edge_sync sync0 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(first_timer_trigger_pin_i),
    .level_o(),
    .rise_o(rise0),
    .fall_o(fall0)
  );

  pin_edge_sync sync1 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(second_timer_trigger_pin_i),
    .level_o(),
    .rise_o(rise1),
    .fall_o(fall1)
  );

  // Shared port pin level for status readback
  pin_edge_sync sync_port (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(shared_port_pin_i),
    .level_o(level0),
    .rise_o(),
    .fall_o()
  );

  // First timer has no cascade source
  timer_channel #(.WIDTH(WIDTH)) timer0 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ctrl_i(ctrl0),
    .reload_i(reload0),
    .load_i(load0),
    .pin_rise_i(rise0),
    .pin_fall_i(fall0),
    .cascade_i(1'b0),
    .count_o(count0),
    .underflow_o(uf0),
    .active_o(),
    .pulse_o(pulse0)
  );

  // Second timer sees first timer underflows
  timer_channel #(.WIDTH(WIDTH)) timer1 (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ctrl_i(ctrl1),
    .reload_i(reload1),
    .load_i(load1),
    .pin_rise_i(rise1),
    .pin_fall_i(fall1),
    .cascade_i(uf0),
    .count_o(count1),
    .underflow_o(uf1),
    .active_o(active1),
    .pulse_o(pulse1)
  );

  // Registered pulse pins; shared pin floats when pulse output is off
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shared_port_pin_o <= 1'b0;
      shared_port_pin_oe_n_o <= 1'b1;
      second_timer_pulse_pin_o <= 1'b0;
    end else begin
      shared_port_pin_o <= pulse0;
      shared_port_pin_oe_n_o <= !ctrl0[PULSE_BIT];
      second_timer_pulse_pin_o <= pulse1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_stopped_holds: assert property (
    !ctrl0[RUN_BIT] && !load0 |=> $stable(count0))
    else $error("Stopped timer 0 counter changed");

  a_timer_decrement: assert property (
    ctrl0[RUN_BIT] && ctrl0[2:1] == MODE_TIMER && count0 != 16'h0000
    |=> count0 == $past(count0) - 16'h0001)
    else $error("Periodic timer did not decrement by one");

  a_periodic_reload: assert property (
    ctrl0[RUN_BIT] && ctrl0[2:1] == MODE_TIMER && count0 == 16'h0000
    |=> count0 == $past(reload0) ##1 count0 == ((!$past(ctrl0[RUN_BIT])
    || $past(reload0, 2) == 16'h0000) ? $past(reload0, 2) : $past(reload0, 2) - 16'h0001))
    else $error("Periodic timer did not reload and continue");

  a_flag_on_uf: assert property (
    uf0 || uf1 |=> (flags[0] || !$past(uf0)) && (flags[1] || !$past(uf1)))
    else $error("Underflow did not set request flag");

  a_cascade_count: assert property (
    ctrl1[RUN_BIT] && ctrl1[2:1] == MODE_EVENT && ctrl1[SRC_BIT]
    && count1 != 16'h0000 && !uf0 |=> $stable(count1))
    else $error("Second timer counted without first underflow");

  a_cascade_start: assert property (
    ctrl1[RUN_BIT] && ctrl1[2:1] == MODE_ONESHOT && ctrl1[TRIG_BIT]
    && ctrl1[SRC_BIT] && !active1 && uf0 |=> active1)
    else $error("First underflow did not start second timer");

  a_pulse_rises: assert property (
    $rose(active1) && ctrl1[PULSE_BIT] |=> second_timer_pulse_pin_o)
    else $error("Pulse pin did not rise at one-shot start");

  a_oneshot_end: assert property (
    ctrl1[RUN_BIT] && active1 && count1 == 16'h0000
    |=> !active1 && count1 == $past(reload1) && flags[1]
    ##1 !second_timer_pulse_pin_o)
    else $error("One-shot end sequence wrong");

  a_pin_released: assert property (
    !ctrl0[PULSE_BIT] |=> shared_port_pin_oe_n_o)
    else $error("Shared pin driven with pulse output off");

  c_cascade_uf: cover property (uf0 && ctrl1[2:1] == MODE_EVENT ##1 uf1);
  c_oneshot_run: cover property ($rose(active1) ##[1:300] $fell(active1));
  c_square_wave: cover property ($rose(shared_port_pin_o) && !shared_port_pin_oe_n_o);
  c_event_zero: cover property (ctrl0[2:1] == MODE_EVENT && fall0 && count0 == 16'h0000);
endmodule // cascadable_down_timer_pair

/* File: timer_pair_pkg.sv */
// Purpose: Shared constants and types for the cascadable down timer pair
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Control register layout is common to both timers
package timer_pair_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL0_OFFSET = 8'h00;
  localparam logic [7:0] RELOAD0_OFFSET = 8'h04;
  localparam logic [7:0] COUNT0_OFFSET = 8'h08;
  localparam logic [7:0] CTRL1_OFFSET = 8'h0c;
  localparam logic [7:0] RELOAD1_OFFSET = 8'h10;
  localparam logic [7:0] COUNT1_OFFSET = 8'h14;
  localparam logic [7:0] STATUS_OFFSET = 8'h18;

  // Control field positions
  localparam int RUN_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int PULSE_BIT = 3;
  localparam int TRIG_BIT = 4;
  localparam int EDGE_BIT = 5;
  localparam int SRC_BIT = 6;

  // Status field positions
  localparam int FLAG0_BIT = 0;
  localparam int FLAG1_BIT = 1;
  localparam int PIN_BIT = 2;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_ONESHOT = 2'b10
  } mode_type;

  typedef enum logic {
    OS_IDLE = 1'b0,
    OS_ACTIVE = 1'b1
  } os_state_type;

endpackage

/* File: pin_edge_sync.sv */
// Purpose: Synchronise a pin and report its edges
// Assumes: Pin may change at any time
// Notes: Edges are taken between the second and third stage only
`timescale 1ns/10ps
module pin_edge_sync (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic last;
  logic [2:0] fill;

  // Two-stage synchroniser plus history stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  // Marks when the history stage holds a real sample, so no false edge follows reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fill <= 3'h0;
    end else begin
      fill <= {fill[1:0], 1'b1};
    end
  end

  // Edge pulses from synchronised samples only
  assign level_o = sync;
  assign rise_o = fill[2] & sync & ~last;
  assign fall_o = fill[2] & ~sync & last;
endmodule // pin_edge_sync

/* File: timer_channel.sv */
// Purpose: One 16-bit down counter with timer, event and one-shot modes
// Assumes: Control and reload come from the register block
// Notes: Reload is copied to the counter on load_i only while stopped
`timescale 1ns/10ps
module timer_channel import timer_pair_pkg::*; #(
  parameter int WIDTH = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] ctrl_i,
  input wire logic [WIDTH-1:0] reload_i,
  input wire logic load_i,
  input wire logic pin_rise_i,
  input wire logic pin_fall_i,
  input wire logic cascade_i,
  output logic [WIDTH-1:0] count_o,
  output logic underflow_o,
  output logic active_o,
  output logic pulse_o
);
  mode_type mode;
  os_state_type state;
  os_state_type next_state;
  logic [WIDTH-1:0] next_count;
  logic run;
  logic run_q;
  logic toggle;
  logic edge_evt;
  logic ext_evt;
  logic start;
  logic tick;

  // Decode control and event sources
  assign mode = mode_type'(ctrl_i[MODE_LSB+:2]);
  assign run = ctrl_i[RUN_BIT];
  assign edge_evt = ctrl_i[EDGE_BIT] ? pin_rise_i : pin_fall_i;
  assign ext_evt = ctrl_i[SRC_BIT] ? cascade_i : edge_evt;
  assign start = (mode == MODE_ONESHOT) && run && (state == OS_IDLE)
    && (ctrl_i[TRIG_BIT] ? ext_evt : !run_q);
  assign tick = (mode == MODE_TIMER) ? 1'b1
    : (mode == MODE_EVENT) ? ext_evt : (state == OS_ACTIVE);

  // Counting independent of any interrupt gating
  always_comb begin
    next_count = count_o;
    next_state = state;
    underflow_o = 1'b0;
    if (!run) begin
      next_state = OS_IDLE;
      if (load_i) begin
        next_count = reload_i;
      end
    end else if (start) begin
      next_state = OS_ACTIVE;
    end else if (tick) begin
      if (count_o == '0) begin
        next_count = reload_i;
        underflow_o = 1'b1;
        if (mode == MODE_ONESHOT) begin
          next_state = OS_IDLE;
        end
      end else begin
        next_count = count_o - WIDTH'(1);
      end
    end
  end

  // Counter, state and run history
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= COUNT_RESET;
      state <= OS_IDLE;
      run_q <= 1'b0;
    end else begin
      count_o <= next_count;
      state <= next_state;
      run_q <= run;
    end
  end

  // Square wave toggles on each underflow in timer and event modes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      toggle <= 1'b0;
    end else if (!run) begin
      toggle <= 1'b0;
    end else if (underflow_o && mode != MODE_ONESHOT) begin
      toggle <= ~toggle;
    end
  end

  assign active_o = (state == OS_ACTIVE);
  assign pulse_o = ctrl_i[PULSE_BIT]
    & ((mode == MODE_ONESHOT) ? active_o : toggle);
endmodule // timer_channel

/* File: partner_model.sv */
// Purpose: Far side of the timer pins: trigger source and pulled-up pulse load
// Assumes: Trigger lines idle high; shared pin has a pull-up to the supply
// Notes: A fire request pulls the chosen trigger line low for 40 clocks
`timescale 1ns/10ps
module partner_model (
  input wire logic clock_i,
  input wire logic [1:0] fire_i,
  input wire logic pin_i,
  input wire logic oe_n_i,
  output logic [1:0] trig_o,
  output logic level_o
);
  int low_cnt [2] = '{0, 0};

  // Low span per trigger line, so both edges appear far apart
  always @(posedge clock_i) begin
    for (int i = 0; i < 2; i++) begin
      if (fire_i[i]) begin
        low_cnt[i] <= 40;
      end else if (low_cnt[i] > 0) begin
        low_cnt[i] <= low_cnt[i] - 1;
      end
    end
  end

  // Trigger levels and the pulled-up shared pin seen by the block
  assign trig_o[0] = (low_cnt[0] == 0);
  assign trig_o[1] = (low_cnt[1] == 0);
  assign level_o = oe_n_i ? 1'b1 : pin_i;
endmodule // partner_model

/* File: tb.sv */
// Purpose: Self-checking bench for the cascadable down timer pair
// Assumes: AXI4-Lite master drives on rising edges by non-blocking assignment
// Notes: Pin timing is measured in clock cycles at the pins themselves
`timescale 1ns/10ps
module tb import timer_pair_pkg::*;;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pin_o, oe_n, pulse1, lvl;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lb, lr, trig, fire;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  cascadable_down_timer_pair i_dut (.clock_i(clock), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .first_timer_trigger_pin_i(trig[0]), .second_timer_trigger_pin_i(trig[1]),
    .shared_port_pin_i(lvl), .shared_port_pin_o(pin_o),
    .shared_port_pin_oe_n_o(oe_n), .second_timer_pulse_pin_o(pulse1));

  partner_model i_partner (.clock_i(clock), .fire_i(fire), .pin_i(pin_o),
    .oe_n_i(oe_n), .trig_o(trig), .level_o(lvl));

  // Free-running 125 MHz clock
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end

  task automatic summarize;
    $display("Errors %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      summarize;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (awvalid && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1) @(posedge clock);
    lb = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1);
    d = rdata;
    lr = rresp;
    rready <= 0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e);
  endtask

  function automatic logic [31:0] cw(input mode_type m, input logic p, t, e, s);
    return 32'((1 << RUN_BIT) | (m << MODE_LSB) | (p << PULSE_BIT) | (t << TRIG_BIT)
      | (e << EDGE_BIT) | (s << SRC_BIT));
  endfunction

  function automatic logic sel(input int w);
    return w ? pulse1 : pin_o;
  endfunction

  // High time and period of a pulse pin, from one rising edge to the next
  task automatic pin_times(input int w, output int hi, output int per);
    hi = 0;
    while (sel(w) !== 0) @(posedge clock);
    while (sel(w) !== 1) @(posedge clock);
    while (sel(w) === 1) begin
      hi++;
      @(posedge clock);
    end
    per = hi;
    while (sel(w) !== 1) begin
      per++;
      @(posedge clock);
    end
  endtask

  task automatic t_reset;
    logic [31:0] d;
    rc(CTRL0_OFFSET, '1, 32'(CTRL_RESET));
    rc(RELOAD1_OFFSET, '1, 32'(RELOAD_RESET));
    rc(COUNT0_OFFSET, '1, 32'(COUNT_RESET));
    rd(8'h1c, d);
    chk(d, 0);
    chk(lr, RESP_SLVERR);
    wr(8'h1c, 32'h1);
    chk(lb, RESP_SLVERR);
    chk(oe_n, 1);
    wr(RELOAD0_OFFSET, 32'h5);
    repeat (20) @(posedge clock);
    rc(COUNT0_OFFSET, '1, 32'h5);
  endtask

  task automatic t_periodic;
    int hi, per;
    wr(RELOAD0_OFFSET, 32'h4);
    wr(CTRL0_OFFSET, cw(MODE_TIMER, 1, 0, 0, 0));
    pin_times(0, hi, per);
    chk(hi, 4 + 1);
    chk(per, 2 * (4 + 1));
    chk(oe_n, 0);
    rc(STATUS_OFFSET, 32'h1, 32'h1);
    wr(CTRL0_OFFSET, cw(MODE_TIMER, 0, 0, 0, 0));
    @(posedge clock);
    chk(oe_n, 1);
    rc(STATUS_OFFSET, 32'h4, 32'h4);
    wr(CTRL0_OFFSET, 0);
  endtask

  task automatic t_cascade;
    wr(RELOAD0_OFFSET, 99);
    wr(RELOAD1_OFFSET, 5);
    wr(CTRL1_OFFSET, cw(MODE_EVENT, 0, 0, 0, 1));
    wr(CTRL0_OFFSET, cw(MODE_TIMER, 0, 0, 0, 0));
    repeat (250) @(posedge clock);
    rc(COUNT1_OFFSET, '1, 32'h3);
    wr(CTRL0_OFFSET, 0);
    wr(CTRL1_OFFSET, 0);
  endtask

  task automatic t_pwm;
    int hi, per;
    wr(RELOAD0_OFFSET, 19);
    wr(RELOAD1_OFFSET, 4);
    wr(CTRL1_OFFSET, cw(MODE_ONESHOT, 1, 1, 0, 1));
    wr(CTRL0_OFFSET, cw(MODE_TIMER, 0, 0, 0, 0));
    pin_times(1, hi, per);
    chk(per, 20);
    chk(32'(hi >= 4 + 1 && hi <= 4 + 2), 1);
    wr(CTRL0_OFFSET, 0);
    repeat (30) @(posedge clock);
    chk(pulse1, 0);
    rc(COUNT1_OFFSET, '1, 32'h4);
    rc(STATUS_OFFSET, 32'h2, 32'h2);
    wr(CTRL1_OFFSET, 0);
  endtask

  // External trigger start, falling then rising edge select
  task automatic t_trigger;
    wr(RELOAD0_OFFSET, 3);
    wr(STATUS_OFFSET, 32'h1);
    wr(CTRL0_OFFSET, cw(MODE_ONESHOT, 0, 0, 0, 0));
    repeat (20) @(posedge clock);
    rc(STATUS_OFFSET, 32'h1, 32'h1);
    rc(COUNT0_OFFSET, '1, 32'h3);
    for (int e = 0; e < 2; e++) begin
      wr(CTRL0_OFFSET, 0);
      wr(STATUS_OFFSET, 32'h1);
      wr(CTRL0_OFFSET, cw(MODE_ONESHOT, 0, 1, e[0], 0));
      repeat (10) @(posedge clock);
      rc(STATUS_OFFSET, 32'h1, 0);
      fire <= 2'b01;
      @(posedge clock);
      fire <= 0;
      repeat (20) @(posedge clock);
      rc(STATUS_OFFSET, 32'h1, 32'(e == 0));
      repeat (50) @(posedge clock);
      rc(STATUS_OFFSET, 32'h1, 32'h1);
      rc(COUNT0_OFFSET, '1, 32'h3);
    end
    wr(CTRL0_OFFSET, 0);
  endtask

  // Event mode with zero count on each timer's own pin
  task automatic t_event_zero;
    logic [7:0] b;
    for (int t = 0; t < 2; t++) begin
      b = t ? CTRL1_OFFSET : CTRL0_OFFSET;
      wr(b, 0);
      wr(8'(b + 8'h4), 0);
      wr(b, cw(MODE_EVENT, 0, 0, 0, 0));
      wr(STATUS_OFFSET, 32'h3);
      rc(STATUS_OFFSET, 32'(1 << t), 0);
      fire <= 2'(1 << t);
      @(posedge clock);
      fire <= 0;
      repeat (20) @(posedge clock);
      rc(STATUS_OFFSET, 32'(1 << t), 32'(1 << t));
      wr(STATUS_OFFSET, 32'h3);
      repeat (50) @(posedge clock);
      rc(STATUS_OFFSET, 32'(1 << t), 0);
      wr(b, 0);
    end
  endtask

  // Reset, then the scenarios in turn
  initial begin
    rst_n = 0;
    awvalid = 0;
    wvalid = 0;
    bready = 0;
    arvalid = 0;
    rready = 0;
    awaddr = 0;
    araddr = 0;
    wdata = 0;
    wstrb = 4'hf;
    fire = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1;
    t_reset;
    t_periodic;
    t_cascade;
    t_pwm;
    t_trigger;
    t_event_zero;
    summarize;
  end
endmodule // tb
